//--- verilog/ocd_pkg.sv
// Purpose: Shared constants for the oscillator select and clock divisor block.
// Assumes: Word-aligned APB byte addresses, 16-bit registers in the low half of each word.
// Notes:   Oscillator select codes follow the configuration encoding.
`default_nettype none

package ocd_pkg;

   // Register byte addresses
   localparam logic [11:0] ADDR_CTL  = 12'h000;
   localparam logic [11:0] ADDR_CFG  = 12'h004;
   localparam logic [11:0] ADDR_STAT = 12'h008;

   // clock_divisor_control fields
   localparam int CTL_ROI_BIT    = 15;
   localparam int CTL_DOZE_LSB   = 12;
   localparam int CTL_CLOCK_REDUCTION_ENABLE_BIT  = 11;
   localparam int CTL_FRCDIV_LSB = 8;
   localparam int CTL_PLLPOST_LSB = 6;
   localparam int CTL_PLLPRE_LSB = 0;

   // Configuration word fields
   localparam int CFG_OSC_LSB  = 0;
   localparam int CFG_PRI_LSB  = 4;
   localparam int CFG_SECOND_OSCILLATOR_PIN_BIT = 8;

   // Status word fields
   localparam int STAT_SRC_LSB   = 0;
   localparam int STAT_PLL_BIT   = 2;
   localparam int STAT_SECOND_OSCILLATOR_PIN_BIT  = 3;
   localparam int STAT_CLOCK_REDUCTION_ENABLE_BIT = 4;

   // Reset values
   localparam logic [15:0] CTL_RESET = 16'h3040;
   localparam logic [15:0] CFG_RESET = 16'h0137;

   // Oscillator select codes
   localparam logic [2:0] OSC_FRC       = 3'h0;
   localparam logic [2:0] OSC_FRC_PLL   = 3'h1;
   localparam logic [2:0] OSC_PRI       = 3'h2;
   localparam logic [2:0] OSC_PRI_PLL   = 3'h3;
   localparam logic [2:0] OSC_LOW_POWER_RC_OSCILLATOR      = 3'h5;
   localparam logic [2:0] OSC_FRC_DIV16 = 3'h6;
   localparam logic [2:0] OSC_FRC_DIVN  = 3'h7;

   // Primary mode codes
   localparam logic [1:0] PRI_EC = 2'h0;
   localparam logic [1:0] PRI_XT = 2'h1;
   localparam logic [1:0] PRI_HS = 2'h2;

   // Divider exponent and reserved PLL divider code
   localparam logic [3:0] FRC_DIV16_EXP = 4'h4;
   localparam logic [1:0] PLLPOST_RSVD  = 2'h2;

   typedef enum logic [1:0] {
      OCD_SRC_FRC,
      OCD_SRC_LOW_POWER_RC_OSCILLATOR,
      OCD_SRC_PRI
   } ocd_src_e;

endpackage : ocd_pkg

`default_nettype wire

//--- verilog/ocd_pow2_div.sv
// Purpose: Divides a tick stream by two to the power of a code.
// Assumes: tick_in is a one-cycle strobe in the pclk domain.
// Notes:   Output is a registered one-cycle strobe, one cycle late.
`default_nettype none

module ocd_pow2_div (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       pce,
   input  wire logic       tick_in,
   input  wire logic [3:0] exp_sel,
   output logic            tick_out
);

   typedef struct packed {
      logic [7:0] cnt;
      logic       out;
   } ocd_div_s;

   ocd_div_s   st_ff;
   ocd_div_s   nxt_st;
   logic [8:0] span;
   logic [7:0] mask;

   always_comb begin
      span = (9'h001 << exp_sel) - 9'h001;
      mask = span[7:0];
      nxt_st = st_ff;
      nxt_st.out = 1'b0;
      if (tick_in) begin
         // Compare, not equal: a shrinking code must not strand the count
         if (st_ff.cnt >= mask) begin
            nxt_st.cnt = 8'h00;
            nxt_st.out = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else if (pce) begin
         st_ff <= nxt_st;
      end
   end

   assign tick_out = st_ff.out;

endmodule : ocd_pow2_div

`default_nettype wire

//--- verilog/ocd_clk_ctrl.sv
// Purpose: Oscillator selection and clock divisor control with an APB slave.
// Assumes: Clock sources arrive as one-cycle ticks in the pclk domain.
// Notes:   Configuration word stands in for non-volatile fuses.
// How it works
// - With recover flag set, any interrupt clears the reduction enable.
// - Reduction code divides instruction clock by two to the code; reset 011.
// - Enable set applies reduction ratio; enable clear forces one to one.
// - Reduction code writes are ignored while the enable is set.
// - Setting the enable is refused when the reduction code after the write is 000.
// - Fast RC postscaler divides fast RC by two to its code; code 111 divides by 256.
// - PLL output divider: 11 by 8, 01 by 4; 10 reserved.
// - Internal modes decode from select code; primary mode field ignored.
// - Select 011 uses primary through PLL, 010 directly; field picks kind.
// - Erased device starts in fast RC divide-by-N mode, code 111.
// - Internal and external-clock modes take pin two function from config.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`default_nettype none

module ocd_clk_ctrl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        pce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        irq_event,
   input  wire logic        frc_tick,
   input  wire logic        pll_vco_tick,
   input  wire logic        instr_tick,
   output logic [1:0]       sys_src_sel,
   output logic             pll_en,
   output logic [1:0]       primary_osc_mode_field,
   output logic             second_oscillator_pin_gpio_en,
   output logic             frc_post_tick,
   output logic             pll_out_tick,
   output logic             cpu_clk_en,
   output logic             periph_clk_en
);

   typedef struct packed {
      logic        interrupt_recover_flag;
      logic [2:0]  doze;
      logic        clock_reduction_enable;
      logic [2:0]  frcdiv;
      logic [1:0]  pllpost;
      logic [4:0]  pllpre;
      logic [2:0]  osc_sel;
      logic [1:0]  pri_mode;
      logic        second_oscillator_pin_fn;
      logic [31:0] rdata;
      logic        err;
   } ocd_ctl_s;

   ocd_ctl_s    st_ff;
   ocd_ctl_s    nxt_st;
   logic        setup;
   logic        access;
   logic        hit_ctl;
   logic        hit_cfg;
   logic        hit_stat;
   logic [31:0] ctl_word;
   logic [31:0] cfg_word;
   logic [31:0] stat_word;
   logic [31:0] wv;
   logic [2:0]  new_doze;
   logic [3:0]  frc_exp;
   logic [3:0]  pll_exp;
   logic [3:0]  doze_exp;
   logic        pin_fixed;

   // Byte-lane merge for partial writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Postscaler skips 128: code 111 jumps straight to 256
   function automatic logic [3:0] frc_post_exp(input logic [2:0] code);
      logic [3:0] e;
      e = {1'b0, code};
      if (code == 3'h7) begin
         e = 4'h8;
      end
      return e;
   endfunction

   // 00 by 2, 01 by 4, 11 by 8
   function automatic logic [3:0] pll_post_exp(input logic [1:0] code);
      logic [3:0] e;
      e = 4'h1;
      unique case (code)
         2'h0:    e = 4'h1;
         2'h1:    e = 4'h2;
         2'h3:    e = 4'h3;
         default: e = 4'h2;
      endcase
      return e;
   endfunction

   assign setup    = psel & ~penable;
   assign access   = psel & penable;
   assign hit_ctl  = (paddr == ocd_pkg::ADDR_CTL);
   assign hit_cfg  = (paddr == ocd_pkg::ADDR_CFG);
   assign hit_stat = (paddr == ocd_pkg::ADDR_STAT);

   always_comb begin
      ctl_word = 32'h0000_0000;
      ctl_word[ocd_pkg::CTL_ROI_BIT] = st_ff.interrupt_recover_flag;
      ctl_word[ocd_pkg::CTL_DOZE_LSB +: 3] = st_ff.doze;
      ctl_word[ocd_pkg::CTL_CLOCK_REDUCTION_ENABLE_BIT] = st_ff.clock_reduction_enable;
      ctl_word[ocd_pkg::CTL_FRCDIV_LSB +: 3] = st_ff.frcdiv;
      ctl_word[ocd_pkg::CTL_PLLPOST_LSB +: 2] = st_ff.pllpost;
      ctl_word[ocd_pkg::CTL_PLLPRE_LSB +: 5] = st_ff.pllpre;
      cfg_word = 32'h0000_0000;
      cfg_word[ocd_pkg::CFG_OSC_LSB +: 3] = st_ff.osc_sel;
      cfg_word[ocd_pkg::CFG_PRI_LSB +: 2] = st_ff.pri_mode;
      cfg_word[ocd_pkg::CFG_SECOND_OSCILLATOR_PIN_BIT] = st_ff.second_oscillator_pin_fn;
      stat_word = 32'h0000_0000;
      stat_word[ocd_pkg::STAT_SRC_LSB +: 2] = sys_src_sel;
      stat_word[ocd_pkg::STAT_PLL_BIT] = pll_en;
      stat_word[ocd_pkg::STAT_SECOND_OSCILLATOR_PIN_BIT] = second_oscillator_pin_gpio_en;
      stat_word[ocd_pkg::STAT_CLOCK_REDUCTION_ENABLE_BIT] = st_ff.clock_reduction_enable;
   end

   // Source decode from the configuration select code
   always_comb begin
      sys_src_sel = ocd_pkg::OCD_SRC_FRC;
      pll_en      = 1'b0;
      pin_fixed   = 1'b0;
      frc_exp     = 4'h0;
      unique case (st_ff.osc_sel)
         ocd_pkg::OSC_FRC_DIVN: begin
            frc_exp = frc_post_exp(st_ff.frcdiv);
         end
         ocd_pkg::OSC_FRC_DIV16: begin
            frc_exp = ocd_pkg::FRC_DIV16_EXP;
         end
         ocd_pkg::OSC_LOW_POWER_RC_OSCILLATOR: begin
            sys_src_sel = ocd_pkg::OCD_SRC_LOW_POWER_RC_OSCILLATOR;
         end
         ocd_pkg::OSC_PRI_PLL: begin
            sys_src_sel = ocd_pkg::OCD_SRC_PRI;
            pll_en      = 1'b1;
            pin_fixed   = (st_ff.pri_mode != ocd_pkg::PRI_EC);
         end
         ocd_pkg::OSC_PRI: begin
            sys_src_sel = ocd_pkg::OCD_SRC_PRI;
            pin_fixed   = (st_ff.pri_mode != ocd_pkg::PRI_EC);
         end
         ocd_pkg::OSC_FRC_PLL: begin
            pll_en  = 1'b1;
            frc_exp = frc_post_exp(st_ff.frcdiv);
         end
         ocd_pkg::OSC_FRC: begin
            frc_exp = 4'h0;
         end
         default: begin
            frc_exp = 4'h0;
         end
      endcase
   end

   // Primary modes other than EC own the second pin; others follow the config bit
   assign second_oscillator_pin_gpio_en = ~pin_fixed & st_ff.second_oscillator_pin_fn;
   assign primary_osc_mode_field = st_ff.pri_mode;

   assign pll_exp  = pll_post_exp(st_ff.pllpost);
   assign doze_exp = st_ff.clock_reduction_enable ? {1'b0, st_ff.doze} : 4'h0;

   always_comb begin
      nxt_st   = st_ff;
      wv       = lane_merge(ctl_word, pwdata, pstrb);
      new_doze = st_ff.clock_reduction_enable ? st_ff.doze : wv[ocd_pkg::CTL_DOZE_LSB +: 3];
      if (setup) begin
         nxt_st.err   = ~(hit_ctl | hit_cfg | (hit_stat & ~pwrite));
         nxt_st.rdata = 32'h0000_0000;
         if (!pwrite && hit_ctl) begin
            nxt_st.rdata = ctl_word;
         end else if (!pwrite && hit_cfg) begin
            nxt_st.rdata = cfg_word;
         end else if (!pwrite && hit_stat) begin
            nxt_st.rdata = stat_word;
         end
      end
      if (access && pwrite && hit_ctl) begin
         nxt_st.interrupt_recover_flag    = wv[ocd_pkg::CTL_ROI_BIT];
         nxt_st.doze   = new_doze;
         // Refused when the code after this write is zero
         nxt_st.clock_reduction_enable  = wv[ocd_pkg::CTL_CLOCK_REDUCTION_ENABLE_BIT] & (new_doze != 3'h0);
         nxt_st.frcdiv = wv[ocd_pkg::CTL_FRCDIV_LSB +: 3];
         nxt_st.pllpre = wv[ocd_pkg::CTL_PLLPRE_LSB +: 5];
         // Reserved divider code is dropped, old value kept
         if (wv[ocd_pkg::CTL_PLLPOST_LSB +: 2] != ocd_pkg::PLLPOST_RSVD) begin
            nxt_st.pllpost = wv[ocd_pkg::CTL_PLLPOST_LSB +: 2];
         end
      end
      if (access && pwrite && hit_cfg) begin
         wv = lane_merge(cfg_word, pwdata, pstrb);
         nxt_st.osc_sel  = wv[ocd_pkg::CFG_OSC_LSB +: 3];
         nxt_st.pri_mode = wv[ocd_pkg::CFG_PRI_LSB +: 2];
         nxt_st.second_oscillator_pin_fn  = wv[ocd_pkg::CFG_SECOND_OSCILLATOR_PIN_BIT];
      end
      // Hardware clear beats a same-cycle software set
      if (irq_event && st_ff.interrupt_recover_flag) begin
         nxt_st.clock_reduction_enable = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff          <= '0;
         st_ff.interrupt_recover_flag      <= ocd_pkg::CTL_RESET[ocd_pkg::CTL_ROI_BIT];
         st_ff.doze     <= ocd_pkg::CTL_RESET[ocd_pkg::CTL_DOZE_LSB +: 3];
         st_ff.clock_reduction_enable    <= ocd_pkg::CTL_RESET[ocd_pkg::CTL_CLOCK_REDUCTION_ENABLE_BIT];
         st_ff.frcdiv   <= ocd_pkg::CTL_RESET[ocd_pkg::CTL_FRCDIV_LSB +: 3];
         st_ff.pllpost  <= ocd_pkg::CTL_RESET[ocd_pkg::CTL_PLLPOST_LSB +: 2];
         st_ff.pllpre   <= ocd_pkg::CTL_RESET[ocd_pkg::CTL_PLLPRE_LSB +: 5];
         st_ff.osc_sel  <= ocd_pkg::CFG_RESET[ocd_pkg::CFG_OSC_LSB +: 3];
         st_ff.pri_mode <= ocd_pkg::CFG_RESET[ocd_pkg::CFG_PRI_LSB +: 2];
         st_ff.second_oscillator_pin_fn  <= ocd_pkg::CFG_RESET[ocd_pkg::CFG_SECOND_OSCILLATOR_PIN_BIT];
      end else if (pce) begin
         st_ff <= nxt_st;
      end
   end

   // Zero wait states; a frozen block holds the bus off
   assign pready  = access & pce;
   assign prdata  = st_ff.rdata;
   assign pslverr = pready & st_ff.err;
   assign periph_clk_en = instr_tick;

   ocd_pow2_div u_frc_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .pce      (pce),
      .tick_in  (frc_tick),
      .exp_sel  (frc_exp),
      .tick_out (frc_post_tick)
   );

   ocd_pow2_div u_pll_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .pce      (pce),
      .tick_in  (pll_vco_tick),
      .exp_sel  (pll_exp),
      .tick_out (pll_out_tick)
   );

   ocd_pow2_div u_doze_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .pce      (pce),
      .tick_in  (instr_tick),
      .exp_sel  (doze_exp),
      .tick_out (cpu_clk_en)
   );

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic ctl_wr;
   assign ctl_wr = access & pwrite & hit_ctl & pce;

   property p_roi_clear;
      irq_event && st_ff.interrupt_recover_flag && pce |=> !st_ff.clock_reduction_enable;
   endproperty
   a_roi_clear: assert property (p_roi_clear)
      else $error("interrupt with recover flag left reduction enabled");

   property p_roi_hold;
      irq_event && !st_ff.interrupt_recover_flag && pce && !ctl_wr |=> $stable(st_ff.clock_reduction_enable);
   endproperty
   a_roi_hold: assert property (p_roi_hold)
      else $error("interrupt changed reduction enable without recover flag");

   property p_ratio_one;
      !st_ff.clock_reduction_enable && instr_tick && pce && !ctl_wr ##1 pce |-> cpu_clk_en;
   endproperty
   a_ratio_one: assert property (p_ratio_one)
      else $error("processor tick missing with reduction disabled");

   property p_doze_lock;
      st_ff.clock_reduction_enable && ctl_wr |=> st_ff.doze == $past(st_ff.doze);
   endproperty
   a_doze_lock: assert property (p_doze_lock)
      else $error("reduction code changed while enabled");

   property p_clock_reduction_enable_refuse;
      st_ff.clock_reduction_enable |-> st_ff.doze != 3'h0;
   endproperty
   a_clock_reduction_enable_refuse: assert property (p_clock_reduction_enable_refuse)
      else $error("reduction enabled with code zero");

   property p_pll_rsvd;
      st_ff.pllpost != ocd_pkg::PLLPOST_RSVD;
   endproperty
   a_pll_rsvd: assert property (p_pll_rsvd)
      else $error("reserved PLL divider code stored");

   property p_low_power_rc_oscillator_sel;
      st_ff.osc_sel == ocd_pkg::OSC_LOW_POWER_RC_OSCILLATOR |->
         sys_src_sel == ocd_pkg::OCD_SRC_LOW_POWER_RC_OSCILLATOR && !pll_en;
   endproperty
   a_low_power_rc_oscillator_sel: assert property (p_low_power_rc_oscillator_sel)
      else $error("low-power RC select not decoded");

   property p_pri_pll;
      st_ff.osc_sel == ocd_pkg::OSC_PRI_PLL |->
         sys_src_sel == ocd_pkg::OCD_SRC_PRI && pll_en;
   endproperty
   a_pri_pll: assert property (p_pri_pll)
      else $error("primary with PLL not decoded");

   property p_second_oscillator_pin_fn;
      st_ff.osc_sel != ocd_pkg::OSC_PRI && st_ff.osc_sel != ocd_pkg::OSC_PRI_PLL
         |-> second_oscillator_pin_gpio_en == st_ff.second_oscillator_pin_fn;
   endproperty
   a_second_oscillator_pin_fn: assert property (p_second_oscillator_pin_fn)
      else $error("second pin function ignores config bit in internal mode");

   c_roi_clear: cover property (irq_event && st_ff.interrupt_recover_flag && st_ff.clock_reduction_enable);
   c_clock_reduction_enable_set: cover property (!st_ff.clock_reduction_enable ##1 st_ff.clock_reduction_enable);
   c_doze_tick: cover property (st_ff.clock_reduction_enable && cpu_clk_en);
   c_bad_addr:  cover property (pslverr);

endmodule : ocd_clk_ctrl

`default_nettype wire

//--- tb/test_ocd_clk_ctrl.sv
// Purpose: Self-checking bench for the oscillator select and clock divisor block.
// Assumes: Zero-wait APB slave; source ticks held high give one tick per cycle.
// Notes:   Ratios measured over 256 cycles after 256 settle cycles, so phase is moot.
`default_nettype none

module test_ocd_clk_ctrl;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq_event = 1'b0;
   logic        frc_tick = 1'b0;
   logic        pll_vco_tick = 1'b0;
   logic        instr_tick = 1'b0;
   logic [1:0]  sys_src_sel;
   logic        pll_en;
   logic [1:0]  primary_osc_mode_field;
   logic        second_oscillator_pin_gpio_en;
   logic        frc_post_tick;
   logic        pll_out_tick;
   logic        cpu_clk_en;
   logic        periph_clk_en;
   int          n_mismatch = 0;
   int          checks = 0;
   logic [31:0] q;
   logic        e;
   int          cf, cp, cc, ci;
   int          pexp, src;
   logic [1:0]  pst;
   logic [2:0]  sc [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
   logic        osc;

   always #4 pclk = ~pclk;

   ocd_clk_ctrl uut (
      .pclk                   (pclk),
      .presetn                (presetn),
      .pce                    (1'b1),
      .psel                   (psel),
      .penable                (penable),
      .pwrite                 (pwrite),
      .paddr                  (paddr),
      .pwdata                 (pwdata),
      .pstrb                  (4'hF),
      .prdata                 (prdata),
      .pready                 (pready),
      .pslverr                (pslverr),
      .irq_event              (irq_event),
      .frc_tick               (frc_tick),
      .pll_vco_tick           (pll_vco_tick),
      .instr_tick             (instr_tick),
      .sys_src_sel            (sys_src_sel),
      .pll_en                 (pll_en),
      .primary_osc_mode_field (primary_osc_mode_field),
      .second_oscillator_pin_gpio_en           (second_oscillator_pin_gpio_en),
      .frc_post_tick          (frc_post_tick),
      .pll_out_tick           (pll_out_tick),
      .cpu_clk_en             (cpu_clk_en),
      .periph_clk_en          (periph_clk_en)
   );

   task automatic wrap_up();
      if (n_mismatch == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checks++;
      if (got !== ex) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // Request held until the edge where pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_mismatch++;
         $display("ERROR pready expected 1 seen 0");
         wrap_up();
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Let registered outputs settle before callers look at them
      #1;
   endtask

   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h00000000);
      chk(nm, ex, q);
      chk({nm, " err"}, 32'h00000000, {31'h0, e});
   endtask

   // Settle first, then count pulses of every divided output
   task automatic measure();
      repeat (256) @(posedge pclk);
      cf = 0;
      cp = 0;
      cc = 0;
      ci = 0;
      repeat (256) begin
         @(posedge pclk);
         #1;
         if (frc_post_tick === 1'b1) cf++;
         if (pll_out_tick === 1'b1) cp++;
         if (cpu_clk_en === 1'b1) cc++;
         if (periph_clk_en === 1'b1) ci++;
      end
   endtask

   function automatic logic [31:0] ctl(logic interrupt_recover_flag, logic [2:0] dz, logic en, logic [2:0] fr,
                                       logic [1:0] pl, logic [4:0] pre);
      return {16'h0000, interrupt_recover_flag, dz, en, fr, pl, 1'b0, pre};
   endfunction

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd("ctl reset", ocd_pkg::ADDR_CTL, 32'h00003040);
      rd("cfg reset", ocd_pkg::ADDR_CFG, 32'h00000137);
      rd("stat reset", ocd_pkg::ADDR_STAT, 32'h00000008);
      chk("src reset", 32'h0, {30'h0, sys_src_sel});
      apb(1'b0, 12'h00C, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, e});
      apb(1'b1, ocd_pkg::ADDR_STAT, 32'h0000001F);
      chk("ro write err", 32'h1, {31'h0, e});
      rd("stat kept", ocd_pkg::ADDR_STAT, 32'h00000008);
      foreach (sc[i]) begin
         for (int p = 0; p < 3; p++) begin
            for (int b = 0; b < 2; b++) begin
               apb(1'b1, ocd_pkg::ADDR_CFG, {23'h0, b[0], 2'h0, p[1:0], 1'b0, sc[i]});
               src = (sc[i] == 3'h5) ? 1 : (sc[i] == 3'h2 || sc[i] == 3'h3) ? 2 : 0;
               osc = ((sc[i] == 3'h2 || sc[i] == 3'h3) && p != 0) ? 1'b0 : b[0];
               chk("src", src, {30'h0, sys_src_sel});
               chk("pll", {31'h0, sc[i] == 3'h1 || sc[i] == 3'h3}, {31'h0, pll_en});
               chk("pri", p, {30'h0, primary_osc_mode_field});
               chk("second_oscillator_pin", {31'h0, osc}, {31'h0, second_oscillator_pin_gpio_en});
               rd("stat", ocd_pkg::ADDR_STAT, {28'h0, osc, src[0] == 1'b0 && src != 0
                  ? 1'b0 : 1'b0, 2'h0} | {29'h0, sc[i] == 3'h1 || sc[i] == 3'h3, src[1:0]});
            end
         end
      end
      frc_tick     <= 1'b1;
      pll_vco_tick <= 1'b1;
      instr_tick   <= 1'b1;
      pexp = 2;
      pst  = 2'h1;
      for (int k = 0; k < 8; k++) begin
         if (k[1:0] != 2'h2) begin
            pst  = k[1:0];
            pexp = (pst == 2'h0) ? 1 : (pst == 2'h1) ? 2 : 3;
         end
         // Enable cleared first, so the second write surely lands the code
         repeat (2) apb(1'b1, ocd_pkg::ADDR_CTL, ctl(1'b0, k, 1'b0, k, k[1:0], k));
         measure();
         chk("frc div", 256 >> ((k == 7) ? 8 : k), cf);
         chk("pll div", 256 >> pexp, cp);
         chk("cpu one to one", 256, cc);
         apb(1'b1, ocd_pkg::ADDR_CTL, ctl(1'b0, k, 1'b1, k, k[1:0], k));
         rd("ctl", ocd_pkg::ADDR_CTL, ctl(1'b0, k, k != 0, k, pst, k));
         measure();
         chk("cpu doze", 256 >> k, cc);
         chk("periph", 256, ci);
      end
      apb(1'b1, ocd_pkg::ADDR_CTL, ctl(1'b0, 3'h1, 1'b1, 3'h7, 2'h3, 5'h07));
      rd("doze locked", ocd_pkg::ADDR_CTL, ctl(1'b0, 3'h7, 1'b1, 3'h7, 2'h3, 5'h07));
      for (int r = 1; r >= 0; r--) begin
         repeat (2) apb(1'b1, ocd_pkg::ADDR_CTL, ctl(r[0], 3'h3, 1'b0, 3'h0, 2'h1, 5'h00));
         apb(1'b1, ocd_pkg::ADDR_CTL, ctl(r[0], 3'h3, 1'b1, 3'h0, 2'h1, 5'h00));
         @(posedge pclk);
         irq_event <= 1'b1;
         @(posedge pclk);
         irq_event <= 1'b0;
         rd("irq", ocd_pkg::ADDR_CTL, ctl(r[0], 3'h3, ~r[0], 3'h0, 2'h1, 5'h00));
      end
      wrap_up();
   end
endmodule // test_ocd_clk_ctrl

`default_nettype wire
